/* File: pkg/afesc_pkg.sv */
// Purpose: shared constants and types of the sampling channel control
// Assumes: 4-bit register index, 8-bit register data
// Notes: register offsets are word indices on the plain register port
package afesc_pkg;
  localparam int AW = 4;
  localparam int DW = 8;
  // register indices
  localparam logic [3:0] A_CTRL = 4'h0;
  localparam logic [3:0] A_TIME = 4'h1;
  localparam logic [3:0] A_CLMP = 4'h2;
  localparam logic [3:0] A_STAT = 4'h3;
  localparam logic [3:0] A_OFS0 = 4'h4;
  localparam logic [3:0] A_GAIN0 = 4'h7;
  localparam logic [3:0] A_BUS = 4'ha;
  // ctrl fields
  localparam int F_MODE = 0;
  localparam int F_CDS = 2;
  localparam int F_ICLE = 3;
  localparam int F_FORCE = 4;
  localparam int F_CSRC = 5;
  localparam int F_MODE_SEL = 6;
  // timing fields
  localparam int F_RSP = 0;
  localparam int F_FMT = 2;
  localparam int F_OE = 4;
  // clamp fields
  localparam int F_CLV = 0;
  localparam int F_RNG = 4;
  localparam int F_EXT = 5;
  // reset values
  localparam logic [7:0] RST_CTRL = 8'h04;
  localparam logic [7:0] RST_TIME = 8'h00;
  localparam logic [7:0] RST_CLMP = 8'h00;
  localparam logic [7:0] RST_COEF = 8'h00;
  // cycles after the video sample at position zero
  localparam logic [3:0] RSP_BASE = 4'h1;
  localparam logic [3:0] PIX_MAX = 4'hf;
  typedef enum logic [1:0] {
    MODE_PIXEL = 2'h0,
    MODE_MONO = 2'h1,
    MODE_LINE = 2'h2
  } afesc_mode_t;
  typedef enum logic [1:0] {
    COL_RED = 2'h0,
    COL_GREEN = 2'h1,
    COL_BLUE = 2'h2
  } afesc_colour_t;
  typedef enum logic [1:0] {
    FMT_86 = 2'h0,
    FMT_86B = 2'h1,
    FMT_77 = 2'h2,
    FMT_NIB = 2'h3
  } afesc_fmt_t;
  typedef enum logic [1:0] {
    OS_IDLE = 2'b01,
    OS_SHIFT = 2'b10
  } afesc_os_t;
endpackage

/* File: pkg/afesc_ctl_if.sv */
// Purpose: link between control top and colour sequencer
// Assumes: single clock domain
// Notes: none
`timescale 1ns/1ps
`default_nettype none
interface afesc_ctl_if;
  import afesc_pkg::*;
  logic advance;
  logic auto_cycle;
  logic forced;
  logic [1:0] mode_sel;
  afesc_colour_t colour;
  modport top (output advance, auto_cycle, forced, mode_sel, input colour);
  modport seq (input advance, auto_cycle, forced, mode_sel, output colour);
endinterface
`default_nettype wire

/* File: core/afesc_seq.sv */
// Purpose: line-by-line colour sequencer
// Assumes: advance is a one-cycle pulse
// Notes: code 3 of the mode select falls back to red
`timescale 1ns/1ps
`default_nettype none
module afesc_seq (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  afesc_ctl_if.seq ctl
);
  import afesc_pkg::*;
  afesc_colour_t colour_reg;
  afesc_colour_t colour_next;
  afesc_colour_t step_col;
  afesc_colour_t forced_col;

  // red, green, blue, red again
  assign step_col = (colour_reg == COL_RED) ? COL_GREEN :
                    (colour_reg == COL_GREEN) ? COL_BLUE : COL_RED; // [R6]
  assign forced_col = (ctl.mode_sel == 2'h3) ? COL_RED :
                      afesc_colour_t'(ctl.mode_sel);
  assign colour_next = ctl.forced ? forced_col : // [R7]
                       (ctl.auto_cycle && ctl.advance) ? step_col :
                       colour_reg;
  assign ctl.colour = colour_reg;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      colour_reg <= COL_RED; // [R20]
    end else begin
      colour_reg <= colour_next;
    end
  end
endmodule
`default_nettype wire

/* File: core/afesc_top.sv */
// Purpose: sampling channel control of a three-channel video front end
// Assumes: all pins synchronous to i_clk_sys, which stands for the
//   master clock
// Notes: registers reached over a plain strobe port
// Function
// R1 - capture clamp/cycle pin on clock edge inside each sync strobe
// R2 - captured high clamps next reset level; low suppresses clamp
// R3 - clamp pulse made internally from clock and sync strobe
// R4 - reset sample position sets clamp and reset-sample timing
// R5 - in auto-cycle the internal clamp enable bit decides clamping
// R6 - each pin pulse in auto-cycle steps red, green, blue, red
// R7 - forced mode, cycle source and mode bits also steer colour
// R8 - line-by-line mode routes selected input into red channel
// R9 - line-by-line mode powers down green and blue channels
// R10 - pixel mode samples all three, converts all in one pixel
// R11 - mono mode samples one software-selected input and channel
// R12 - double sample bit resets to 1; picks reset or pin reference
// R13 - non-DOUBLE_SAMPLE_SELECT samples reference pin together with video level
// R14 - reference pin driven by 4-bit DAC from clamp level code
// R15 - range bit widens clamp DAC range and step
// R16 - external reference bit disables the clamp DAC
// R17 - each channel has its own 8-bit offset and gain codes
// R18 - 14-bit result multiplexed on 8-bit bus in three formats
// R19 - strobe is one clock long; sample on first edge after it falls
// R20 - auto-cycle colour starts at red after reset
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module afesc_top (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [afesc_pkg::AW-1:0] i_reg_addr,
  input wire logic [afesc_pkg::DW-1:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [afesc_pkg::DW-1:0] o_reg_rdata,
  input wire logic i_pixel_sync_strobe,
  input wire logic i_clamp_or_cycle_pin,
  output logic o_video_sample,
  output logic o_reset_sample,
  output logic o_clamp_pulse,
  output logic o_double_sample_select,
  output logic [2:0] o_input_enable,
  output logic [1:0] o_red_chan_source,
  output logic [2:0] o_chan_power,
  output logic o_adc_start,
  output logic [1:0] o_adc_chan,
  output logic [23:0] o_offset_code,
  output logic [23:0] o_gain_code,
  output logic [3:0] o_clamp_level_code,
  output logic o_clamp_dac_range_select,
  output logic o_clamp_dac_enable,
  input wire logic i_conv_valid,
  input wire logic [13:0] i_conv_result,
  input wire logic [1:0] i_conv_chan,
  input wire logic i_conv_overrange,
  input wire logic [7:0] i_data_bus,
  output logic [7:0] o_data_bus,
  output logic o_data_bus_oe,
  output logic o_data_valid
);
  import afesc_pkg::*;

  function automatic logic [2:0] onehot3(input logic [1:0] c);
    onehot3 = 3'h1 << c;
  endfunction

  function automatic logic [7:0] beat(input logic [1:0] fmt,
                                      input logic [15:0] w,
                                      input logic [1:0] ph);
    logic [7:0] b;
    b = 8'h00;
    unique case (fmt)
      FMT_77: b = ph[0] ? {w[8:2], w[0]} : {w[15:9], w[1]};
      FMT_NIB: b = {w[15 - 4 * ph -: 4], 4'h0};
      default: b = ph[0] ? w[7:0] : w[15:8];
    endcase
    beat = b;
  endfunction

  // coefficient routed into the red channel slot
  function automatic logic [7:0] red_slot(input logic line_mode,
                                          input logic [7:0] own,
                                          input logic [7:0] sel);
    red_slot = line_mode ? sel : own;
  endfunction

  // registers
  logic [7:0] ctrl_reg;
  logic [7:0] time_reg;
  logic [7:0] clmp_reg;
  logic [7:0] ofs_reg [3];
  logic [7:0] gain_reg [3];
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // sampling state
  logic strobe_reg;
  logic pin_reg;
  logic cap_reg;
  logic armed_reg;
  logic [3:0] pix_reg;
  logic [1:0] conv_left_reg;
  logic [1:0] conv_idx_reg;
  logic vs_reg;
  logic rs_reg;
  logic clamp_reg;
  logic adc_reg;
  logic [1:0] adc_chan_reg;

  // output serializer
  afesc_os_t os_reg;
  logic [15:0] word_reg;
  logic [1:0] ph_reg;
  logic [7:0] dout_reg;
  logic dval_reg;

  afesc_ctl_if ctl ();

  afesc_seq u_seq (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .ctl(ctl)
  );

  // decoded controls
  wire [1:0] mode = ctrl_reg[F_MODE +: 2];
  wire is_pixel = (mode == MODE_PIXEL);
  wire is_mono = (mode == MODE_MONO);
  wire is_line = (mode == MODE_LINE);
  wire double_sample_select = ctrl_reg[F_CDS];
  wire int_clamp = ctrl_reg[F_ICLE];
  wire forced = ctrl_reg[F_FORCE];
  wire cyc_src = ctrl_reg[F_CSRC];
  wire [1:0] rsp = time_reg[F_RSP +: 2];
  wire [1:0] fmt = time_reg[F_FMT +: 2];
  wire [1:0] colour = ctl.colour;

  // pin acts as cycle input only in line mode with pin stepping
  wire auto_cycle = is_line && cyc_src && !forced;
  wire pin_rise = i_clamp_or_cycle_pin && !pin_reg;
  // sample taken on first edge after the strobe falls
  wire sample_now = strobe_reg && !i_pixel_sync_strobe; // [R19]
  // reset level sample point within the pixel
  wire [3:0] rs_pos = RSP_BASE + {2'h0, rsp}; // [R4]
  wire rs_now = (pix_reg == rs_pos);
  wire clamp_src = auto_cycle ? int_clamp : cap_reg; // [R5]
  wire [1:0] first_chan = is_pixel ? COL_RED :
                          is_line ? COL_RED : colour;

  assign ctl.advance = pin_rise; // [R6]
  assign ctl.auto_cycle = auto_cycle;
  assign ctl.forced = forced; // [R7]
  assign ctl.mode_sel = ctrl_reg[F_MODE_SEL +: 2];

  // register access decode
  wire wr_ctrl = i_reg_wr && (i_reg_addr == A_CTRL);
  wire wr_time = i_reg_wr && (i_reg_addr == A_TIME);
  wire wr_clmp = i_reg_wr && (i_reg_addr == A_CLMP);
  wire is_ofs = (i_reg_addr >= A_OFS0) && (i_reg_addr < A_GAIN0);
  wire is_gain = (i_reg_addr >= A_GAIN0) && (i_reg_addr < A_BUS);
  wire [1:0] ofs_idx = 2'(i_reg_addr - A_OFS0);
  wire [1:0] gain_idx = 2'(i_reg_addr - A_GAIN0);
  wire [7:0] stat_word = {4'h0, cap_reg, armed_reg, colour};

  always_comb begin
    rdata_next = 8'h00;
    if (i_reg_rd) begin
      if (i_reg_addr == A_CTRL) begin
        rdata_next = ctrl_reg;
      end else if (i_reg_addr == A_TIME) begin
        rdata_next = time_reg;
      end else if (i_reg_addr == A_CLMP) begin
        rdata_next = clmp_reg;
      end else if (i_reg_addr == A_STAT) begin
        rdata_next = stat_word;
      end else if (is_ofs) begin
        rdata_next = ofs_reg[ofs_idx];
      end else if (is_gain) begin
        rdata_next = gain_reg[gain_idx];
      end else if (i_reg_addr == A_BUS) begin
        rdata_next = i_data_bus;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      ctrl_reg <= RST_CTRL; // [R12]
      time_reg <= RST_TIME;
      clmp_reg <= RST_CLMP;
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
      if (wr_ctrl) begin
        ctrl_reg <= i_reg_wdata; // [R7] [R11]
      end
      if (wr_time) begin
        time_reg <= i_reg_wdata;
      end
      if (wr_clmp) begin
        clmp_reg <= i_reg_wdata;
      end
    end
  end

  // per-channel coefficient stores
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      for (int i = 0; i < 3; i++) begin
        ofs_reg[i] <= RST_COEF;
        gain_reg[i] <= RST_COEF;
      end
    end else begin
      if (i_reg_wr && is_ofs) begin
        ofs_reg[ofs_idx] <= i_reg_wdata; // [R17]
      end
      if (i_reg_wr && is_gain) begin
        gain_reg[gain_idx] <= i_reg_wdata; // [R17]
      end
    end
  end

  // clamp pin capture and clamp arming
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      strobe_reg <= 1'b0;
      pin_reg <= 1'b0;
      cap_reg <= 1'b0;
      armed_reg <= 1'b0;
    end else begin
      strobe_reg <= i_pixel_sync_strobe;
      pin_reg <= i_clamp_or_cycle_pin;
      if (i_pixel_sync_strobe) begin
        cap_reg <= i_clamp_or_cycle_pin; // [R1]
      end
      if (sample_now) begin
        armed_reg <= clamp_src; // [R2] [R5]
      end
    end
  end

  // pixel timing: reset sample, clamp and video sample pulses
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      pix_reg <= PIX_MAX;
      vs_reg <= 1'b0;
      rs_reg <= 1'b0;
      clamp_reg <= 1'b0;
    end else begin
      if (sample_now) begin
        pix_reg <= 4'h0;
      end else if (pix_reg != PIX_MAX) begin
        pix_reg <= pix_reg + 4'h1;
      end
      vs_reg <= sample_now; // [R19]
      rs_reg <= double_sample_select ? rs_now : sample_now; // [R4] [R13]
      clamp_reg <= rs_now && armed_reg; // [R2] [R3] [R4]
    end
  end

  // converter sequencing within the pixel
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      conv_left_reg <= 2'h0;
      conv_idx_reg <= 2'h0;
      adc_reg <= 1'b0;
      adc_chan_reg <= 2'h0;
    end else begin
      adc_reg <= 1'b0;
      if (sample_now) begin
        conv_left_reg <= is_pixel ? 2'h3 : 2'h1; // [R10] [R11]
        conv_idx_reg <= first_chan;
      end else if (conv_left_reg != 2'h0) begin
        adc_reg <= 1'b1;
        adc_chan_reg <= conv_idx_reg; // [R8] [R10]
        conv_idx_reg <= conv_idx_reg + 2'h1;
        conv_left_reg <= conv_left_reg - 2'h1;
      end
    end
  end

  // result multiplexing onto the data bus
  wire cc_flag = (i_conv_chan == COL_GREEN);
  wire [1:0] last_ph = (fmt == FMT_NIB) ? 2'h3 : 2'h1;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      os_reg <= OS_IDLE;
      word_reg <= 16'h0000;
      ph_reg <= 2'h0;
      dout_reg <= 8'h00;
      dval_reg <= 1'b0;
    end else begin
      dval_reg <= 1'b0;
      unique case (os_reg)
        OS_IDLE: begin
          if (i_conv_valid) begin
            word_reg <= {i_conv_result, cc_flag, i_conv_overrange};
            ph_reg <= 2'h0;
            os_reg <= OS_SHIFT;
          end
        end
        OS_SHIFT: begin
          dout_reg <= beat(fmt, word_reg, ph_reg); // [R18]
          dval_reg <= 1'b1;
          ph_reg <= ph_reg + 2'h1;
          if (ph_reg == last_ph) begin
            os_reg <= OS_IDLE;
          end
        end
        default: begin
          os_reg <= OS_IDLE;
        end
      endcase
    end
  end

  // outputs
  assign o_reg_rdata = rdata_reg;
  assign o_video_sample = vs_reg;
  assign o_reset_sample = rs_reg;
  assign o_clamp_pulse = clamp_reg;
  assign o_double_sample_select = double_sample_select; // [R12]
  assign o_input_enable = is_pixel ? 3'h7 : onehot3(colour); // [R10] [R11]
  assign o_red_chan_source = is_line ? colour : COL_RED; // [R8]
  assign o_chan_power = is_pixel ? 3'h7 :
                        is_line ? 3'h1 : onehot3(colour); // [R9] [R11]
  assign o_adc_start = adc_reg;
  assign o_adc_chan = adc_chan_reg;
  // red channel coefficients follow the colour in line mode
  assign o_offset_code = {ofs_reg[2], ofs_reg[1], // [R6]
                          red_slot(is_line, ofs_reg[0], ofs_reg[colour])};
  assign o_gain_code = {gain_reg[2], gain_reg[1], // [R6]
                        red_slot(is_line, gain_reg[0], gain_reg[colour])};
  assign o_clamp_level_code = clmp_reg[F_CLV +: 4]; // [R14]
  assign o_clamp_dac_range_select = clmp_reg[F_RNG]; // [R15]
  assign o_clamp_dac_enable = !clmp_reg[F_EXT]; // [R16]
  assign o_data_bus = dout_reg;
  assign o_data_bus_oe = time_reg[F_OE];
  assign o_data_valid = dval_reg;
endmodule
`default_nettype wire

/* File: sim/afesc_top_properties.sv */
// Purpose: port-level timing checks of the sampling channel control
// Assumes: one clock, synchronous active-low reset
// Notes: pixel mode is seen as all three inputs enabled
`timescale 1ns/1ps
`default_nettype none
module afesc_top_properties (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_pixel_sync_strobe,
  input wire logic i_clamp_or_cycle_pin,
  input wire logic o_video_sample,
  input wire logic o_reset_sample,
  input wire logic o_clamp_pulse,
  input wire logic o_double_sample_select,
  input wire logic [2:0] o_input_enable,
  input wire logic [1:0] o_red_chan_source,
  input wire logic [2:0] o_chan_power,
  input wire logic o_adc_start,
  input wire logic [1:0] o_adc_chan
);
  wire logic s;
  wire logic pix;
  assign s = i_pixel_sync_strobe;
  assign pix = o_input_enable == 3'h7;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);
  property p_video;
    $fell(s) |-> ##1 o_video_sample;
  endproperty
  a_video: assert property (p_video) else $error("video late");
  property p_adc3;
    $fell(s) && pix |-> ##2 o_adc_start && o_adc_chan == 2'h0
      ##1 o_adc_start && o_adc_chan == 2'h1
      ##1 o_adc_start && o_adc_chan == 2'h2;
  endproperty
  a_adc3: assert property (p_adc3) else $error("adc order");
  property p_adc1;
    $fell(s) && !pix |-> ##2 o_adc_start ##1 !o_adc_start;
  endproperty
  a_adc1: assert property (p_adc1) else $error("adc single");
  property p_clon;
    $fell(s) && $past(i_clamp_or_cycle_pin) && pix |-> ##[2:6] o_clamp_pulse;
  endproperty
  a_clon: assert property (p_clon) else $error("clamp missing");
  property p_cloff;
    $fell(s) && !$past(i_clamp_or_cycle_pin) && pix |-> ##1 !o_clamp_pulse[*6];
  endproperty
  a_cloff: assert property (p_cloff) else $error("clamp extra");
  property p_cds;
    o_double_sample_select && o_clamp_pulse |-> o_reset_sample;
  endproperty
  a_cds: assert property (p_cds) else $error("clamp apart");
  property p_ncds;
    !o_double_sample_select && o_video_sample |-> o_reset_sample;
  endproperty
  a_ncds: assert property (p_ncds) else $error("ref late");
  property p_line;
    o_red_chan_source != 2'h0 |-> o_chan_power == 3'h1;
  endproperty
  a_line: assert property (p_line) else $error("line power");
  c_clamp: cover property (o_clamp_pulse);
  c_blue: cover property (o_red_chan_source == 2'h2);
  c_pix: cover property ($fell(s) && pix);
endmodule
bind afesc_top afesc_top_properties u_props (.i_clk_sys, .i_rst_n,
  .i_pixel_sync_strobe, .i_clamp_or_cycle_pin, .o_video_sample,
  .o_reset_sample, .o_clamp_pulse, .o_double_sample_select,
  .o_input_enable, .o_red_chan_source, .o_chan_power, .o_adc_start,
  .o_adc_chan);
`default_nettype wire

/* File: sim/afesc_sensor_model.sv */
// Purpose: sensor timing controller driving sync strobe and clamp pin
// Assumes: tasks called by one process at a time
// Notes: pin drops with the strobe so only the captured level counts
`timescale 1ns/1ps
`default_nettype none
module afesc_sensor_model (
  input wire logic i_clk_sys,
  output logic o_strobe,
  output logic o_pin
);
  initial begin
    o_strobe = 1'b0;
    o_pin = 1'b0;
  end
  task automatic pixel(input logic lvl, input int slow);
    repeat (slow + 1) @(posedge i_clk_sys);
    o_strobe <= 1'b1;
    o_pin <= lvl;
    @(posedge i_clk_sys);
    o_strobe <= 1'b0;
    o_pin <= 1'b0;
    repeat (9) @(posedge i_clk_sys);
  endtask
  task automatic step();
    @(posedge i_clk_sys);
    o_pin <= 1'b1;
    @(posedge i_clk_sys);
    o_pin <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
  endtask
endmodule
`default_nettype wire

/* File: sim/afesc_top_tb.sv */
// Purpose: self-checking bench of the sampling channel control
// Assumes: 125 MHz clock, reset held 20 cycles
// Notes: reads and result beats go through expectation queues
`timescale 1ns/1ps
`default_nettype none
module afesc_top_tb;
  import afesc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] a = 4'h0;
  logic [7:0] wd = 8'h00, dbi = 8'h00, rdata, dbus;
  logic wr = 1'b0, rd = 1'b0, cv = 1'b0, co = 1'b0, rd_d = 1'b0;
  logic [13:0] cr = 14'h0, res;
  logic [1:0] cc = 2'h0, src;
  logic vs, clp, rs, ad, dss, oe, dv, rng, dacen;
  logic [2:0] ien, pwr;
  logic [23:0] ofs, gn;
  logic [3:0] clv;
  logic [15:0] b, w;
  logic [7:0] v[6];
  logic [7:0] qr[$];
  logic [15:0] qb[$];
  wire strobe, pin;
  int miscompares = 0, total_checks = 0, cyc = 0;
  int tv = 0, tcl = 0, ncl = 0, n0, d0, trs = 0, nad = 0, na0;
  always #4 clk = ~clk;
  afesc_sensor_model sens (.i_clk_sys(clk), .o_strobe(strobe), .o_pin(pin));
  afesc_top dut (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_reg_addr(a), .i_reg_wdata(wd),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
    .i_pixel_sync_strobe(strobe), .i_clamp_or_cycle_pin(pin),
    .o_video_sample(vs), .o_reset_sample(rs), .o_clamp_pulse(clp),
    .o_double_sample_select(dss), .o_input_enable(ien),
    .o_red_chan_source(src), .o_chan_power(pwr), .o_adc_start(ad),
    .o_adc_chan(), .o_offset_code(ofs), .o_gain_code(gn),
    .o_clamp_level_code(clv), .o_clamp_dac_range_select(rng),
    .o_clamp_dac_enable(dacen), .i_conv_valid(cv), .i_conv_result(cr),
    .i_conv_chan(cc), .i_conv_overrange(co), .i_data_bus(dbi),
    .o_data_bus(dbus), .o_data_bus_oe(oe), .o_data_valid(dv));
  task automatic chk(input string n, input logic [23:0] s, e);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wreg(input logic [3:0] ad, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    a <= ad;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] ad, input logic [7:0] e);
    qr.push_back(e);
    @(posedge clk);
    rd <= 1'b1;
    a <= ad;
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  always @(posedge clk) begin
    cyc++;
    rd_d <= rd;
    if (rd_d)
      chk("rdata", 24'(rdata), 24'(qr.pop_front()));
    if (dv) begin
      b = qb.pop_front();
      chk("beat", 24'(dbus & b[15:8]), 24'(b[7:0]));
    end
    if (vs)
      tv = cyc;
    if (rs)
      trs = cyc;
    if (ad)
      nad++;
    if (clp) begin
      tcl = cyc;
      ncl++;
    end
    if (cyc == 20000) begin
      miscompares++;
      test_done();
    end
  end
  initial begin
    void'($urandom(33));
    dbi = 8'($urandom);
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 16; i++)
      if (i != 3 && i != 10) rreg(4'(i), i == 0 ? RST_CTRL : 8'h00);
    #1;
    chk("dss", 24'(dss), 24'h1);
    chk("pwr", 24'(pwr), 24'h7);
    chk("oe", 24'(oe), 24'h0);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      v[i] = 8'($urandom);
      wreg(A_OFS0 + 4'(i), v[i]);
      rreg(A_OFS0 + 4'(i), v[i]);
    end
    wreg(A_STAT, 8'hff);
    wreg(4'hc, 8'h5a);
    rreg(A_STAT, 8'h00);
    rreg(4'hc, 8'h00);
    rreg(A_BUS, dbi);
    #1;
    chk("ofs", ofs, {v[2], v[1], v[0]});
    chk("gain", gn, {v[5], v[4], v[3]});
    $display("test registers done");
    wreg(A_CTRL, 8'h26);
    settle();
    chk("src", 24'(src), 24'h0);
    for (int i = 1; i < 5; i++) begin
      sens.step();
      #1;
      chk("src", 24'(src), 24'(i % 3));
      chk("ofs", 24'(ofs[7:0]), 24'(v[i % 3]));
    end
    n0 = ncl;
    sens.pixel(1'b1, 0);
    chk("clamp", 24'(ncl - n0), 24'h0);
    wreg(A_CTRL, 8'h2e);
    sens.pixel(1'b0, 0);
    chk("clamp", 24'(ncl - n0), 24'h1);
    $display("test cycle done");
    for (int k = 0; k < 4; k++) begin
      wreg(A_CTRL, {2'(k), 6'h15});
      na0 = nad;
      sens.pixel(1'b1, 0);
      chk("ien", 24'(ien), k == 3 ? 24'h1 : 24'(1 << k));
      chk("adc", 24'(nad - na0), 24'h1);
      wreg(A_CTRL, {2'(k), 6'h16});
      settle();
      chk("src", 24'(src), k == 3 ? 24'h0 : 24'(k));
      chk("pwr", 24'(pwr), 24'h1);
    end
    $display("test forced done");
    wreg(A_CTRL, RST_CTRL);
    for (int p = 0; p < 4; p++) begin
      wreg(A_TIME, 8'(p));
      n0 = ncl;
      sens.pixel(1'b1, $urandom_range(3));
      if (p == 0)
        d0 = tcl - tv;
      chk("pos", 24'(tcl - tv - d0), 24'(p));
      chk("rs", 24'(trs), 24'(tcl));
      sens.pixel(1'b0, 0);
      chk("clamp", 24'(ncl - n0), 24'h1);
    end
    wreg(A_CTRL, 8'h00);
    na0 = nad;
    sens.pixel(1'b1, 0);
    chk("dss", 24'(dss), 24'h0);
    chk("rs", 24'(trs), 24'(tv));
    chk("adc", 24'(nad - na0), 24'h3);
    $display("test sampling done");
    for (int i = 0; i < 4; i++) begin
      v[0] = {2'h0, 2'(i), 4'($urandom)};
      wreg(A_CLMP, v[0]);
      #1;
      chk("clv", 24'(clv), 24'(v[0][3:0]));
      chk("rng", 24'(rng), 24'(v[0][4]));
      chk("dac", 24'(dacen), 24'(!v[0][5]));
    end
    $display("test dac done");
    for (int f = 0; f < 4; f++) begin
      wreg(A_TIME, {4'h1, 2'(f), 2'h0});
      res = 14'($urandom);
      cc <= 2'($urandom_range(2));
      co <= 1'($urandom);
      @(posedge clk);
      w = {res, cc == 2'h1, co};
      if (f < 2) begin
        qb.push_back({8'hff, w[15:8]});
        qb.push_back({8'hff, w[7:0]});
      end else if (f == 2) begin
        qb.push_back({8'hff, w[15:9], w[1]});
        qb.push_back({8'hff, w[8:2], w[0]});
      end else
        for (int j = 3; j >= 0; j--)
          qb.push_back({8'hf0, w[4*j+:4], 4'h0});
      cv <= 1'b1;
      cr <= res;
      @(posedge clk);
      cv <= 1'b0;
      settle();
      repeat (4) @(posedge clk);
      chk("oe", 24'(oe), 24'h1);
    end
    chk("left", 24'(qr.size() + qb.size()), 24'h0);
    $display("test formats done");
    test_done();
  end
endmodule
`default_nettype wire
